// [core/actc_pkg.sv]
package actc_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] ACTC_ADDR_CFG1   = 3'h0;
    localparam logic [2:0] ACTC_ADDR_CFG2   = 3'h1;
    localparam logic [2:0] ACTC_ADDR_CFG3   = 3'h2;
    localparam logic [2:0] ACTC_ADDR_RESULT = 3'h3;
    localparam logic [2:0] ACTC_ADDR_CTRL   = 3'h4;
    localparam logic [2:0] ACTC_ADDR_STATUS = 3'h5;

    // Configuration register layout, all fields reset to zero
    localparam logic [7:0] ACTC_CFG_RESET = 8'h00;
    localparam int ACTC_GAIN_MSB = 7;
    localparam int ACTC_GAIN_LSB = 5;
    localparam int ACTC_POL_BIT  = 4;
    localparam int ACTC_SIGN_BIT = 3;
    localparam int ACTC_MAG_MSB  = 2;
    localparam int ACTC_MAG_LSB  = 0;

    // Control register layout
    localparam logic [5:0] ACTC_CTRL_RESET = 6'h00;
    localparam int ACTC_CTRL_ADDR_LO = 0;
    localparam int ACTC_CTRL_ADDR_HI = 1;
    localparam int ACTC_CTRL_SEL_A   = 2;
    localparam int ACTC_CTRL_MODE_LO = 3;
    localparam int ACTC_CTRL_MODE_HI = 4;
    localparam int ACTC_CTRL_SCAN    = 5;

    // Calibration mode codes
    localparam logic [1:0] ACTC_MODE_NORMAL = 2'h0;
    localparam logic [1:0] ACTC_MODE_RSVD   = 2'h3;

    // Source tags and configuration indices
    localparam logic [2:0] ACTC_TAG_DIFF0 = 3'h4;
    localparam logic [2:0] ACTC_TAG_AIN5  = 3'h6;
    localparam logic [2:0] ACTC_TAG_CAL   = 3'h7;
    localparam logic [1:0] ACTC_ADDR_BAD  = 2'h3;
    localparam logic [1:0] ACTC_CFG_IDX3  = 2'h2;
    localparam logic [2:0] ACTC_PSEUDO_N  = 3'h5;
    localparam logic [2:0] ACTC_SELECT_A_N    = 3'h3;
    localparam logic [2:0] ACTC_CAL_N     = 3'h2;

    // Post-processing of the signed filter word
    localparam int ACTC_UNI_SHIFT = 5;
    localparam int ACTC_BIP_SHIFT = 6;
    localparam logic signed [27:0] ACTC_BIP_MID  = 28'sh0020000;
    localparam logic signed [27:0] ACTC_RES_MAX  = 28'sh003ffff;
    localparam logic signed [27:0] ACTC_RES_MIN  = 28'sh0000000;
    localparam logic [27:0]        ACTC_OFS_STEP = 28'h0155555;

    // Result word buffer
    localparam int ACTC_FIFO_W = 24;
    localparam int ACTC_FIFO_D = 32;
    localparam logic [2:0] ACTC_RSV_ZERO = 3'h0;
endpackage : actc_pkg

// [core/actc_fifo.sv]
`timescale 1ns/100ps
module actc_fifo #(
    parameter int W = 24,
    parameter int D = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_reg [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic [AW:0]   count_next;
    logic          push;
    logic          pop;

    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_valid = (count_reg != '0);
    assign o_out_data  = mem_reg[rd_ptr_reg];

    // Occupancy after this cycle
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Pointers, count and registered ready
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            o_in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            count_reg  <= count_next;
            o_in_ready <= (count_next != (AW + 1)'(D));
        end
    end

    // Storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end
endmodule // actc_fifo

// [core/actc_top.sv]
// Functional notes
// R1: Polarity bit 0 means bipolar mapping, 1 means unipolar mapping.
// R2: Polarity only changes filter post-processing, never front-end controls.
// R3: Modulator always runs bipolar; equal inputs give half ones density.
// R4: Host sets polarity before converting; stored results never rewritten.
// R5: Gain code n selects gain two to the power n, x1 to x128.
// R6: Offset code top bit is sign, lower three bits magnitude.
// R7: Zero magnitude, either sign, disconnects offset DAC; default all zero.
// R8: Offset step is one twelfth of bipolar range, one sixth unipolar.
// R9: Normal mode maps pairs to registers 1,2,3; differential address 3 barred.
// R10: Offset calibration uses addressed register; in scanning register 3.
// R11: Gain calibration uses addressed register; in scanning register 3.
// R12: Result is 24-bit read-only; writes to it change nothing.
// R13: After a result write host sends eight bits before idle returns.
// R14: Result sent MSB first: 18 data bits, three zeros, source tag.
// R15: Result is offset binary, zeros minimum, ones maximum.
// R16: Out-of-range inputs clamp to minimum or maximum code.
// R17: The three bits between data and tag always read zero.
// R18: Tags 0-3 pseudo pairs, 4-6 differential pairs, 7 calibration.
// R19: Config layout gain[7:5], polarity[4], offset[3:0]; resets to zero.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
module actc_top
    import actc_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    input  wire logic [2:0]  I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [23:0] O_RDATA,
    input  wire logic        I_FILT_VALID,
    input  wire logic [23:0] I_FILT_DATA,
    output logic             O_FILT_READY,
    output logic             O_CONV_ENABLE,
    output logic      [1:0]  O_CFG_SEL,
    output logic      [2:0]  O_SOURCE_TAG,
    output logic      [7:0]  O_PGA_GAIN,
    output logic             O_DAC_NEG,
    output logic      [2:0]  O_DAC_MAG,
    output logic             O_DAC_CONNECT,
    output logic             O_MOD_BIPOLAR
);
    // Channel selection: {usable, config index, source tag}
    function automatic logic [5:0] chan_sel(input logic [5:0] ctrl,
                                            input logic [2:0] step);
        logic [1:0] mode;
        logic [1:0] addr;
        logic       sel_a;
        logic       ok;
        logic [1:0] cfg;
        logic [2:0] tag;
        logic [2:0] base;
        mode  = {ctrl[ACTC_CTRL_MODE_HI], ctrl[ACTC_CTRL_MODE_LO]};
        addr  = {ctrl[ACTC_CTRL_ADDR_HI], ctrl[ACTC_CTRL_ADDR_LO]};
        sel_a = ctrl[ACTC_CTRL_SEL_A];
        ok    = (mode != ACTC_MODE_RSVD);
        cfg   = '0;
        tag   = '0;
        base  = sel_a ? ACTC_SELECT_A_N : ACTC_PSEUDO_N;
        if (ctrl[ACTC_CTRL_SCAN]) begin
            // Scanning: inputs first, then both calibration inputs when a calibration mode is set
            if (step >= base) begin
                // R10 R11 scan uses third
                cfg = ACTC_CFG_IDX3;
                tag = ACTC_TAG_CAL;
            end else if (sel_a) begin
                cfg = step[1:0];
                tag = ACTC_TAG_DIFF0 + step;
            end else if (step == (ACTC_PSEUDO_N - 3'h1)) begin
                cfg = ACTC_CFG_IDX3;
                tag = ACTC_TAG_AIN5;
            end else begin
                cfg = {1'b0, step[1]};
                tag = step;
            end
        end else begin
            // R9 addressed register choice
            if (sel_a) begin
                // Barred pair keeps a legal index, no empty slot read
                cfg = (addr == ACTC_ADDR_BAD) ? 2'h0 : addr;
                tag = ACTC_TAG_DIFF0 + {1'b0, addr};
                ok  = ok && (addr != ACTC_ADDR_BAD);
            end else begin
                cfg = {1'b0, addr[1]};
                tag = {1'b0, addr};
            end
            // R18 calibration tag
            if (mode != ACTC_MODE_NORMAL) begin
                tag = ACTC_TAG_CAL;
            end
        end
        return {ok, cfg, tag};
    endfunction

    // Scan length for the current control setting
    function automatic logic [2:0] scan_len(input logic [5:0] ctrl);
        logic [2:0] n;
        n = ctrl[ACTC_CTRL_SEL_A] ? ACTC_SELECT_A_N : ACTC_PSEUDO_N;
        if ({ctrl[ACTC_CTRL_MODE_HI], ctrl[ACTC_CTRL_MODE_LO]}
                != ACTC_MODE_NORMAL) begin
            n = n + ACTC_CAL_N;
        end
        return n;
    endfunction

    // Map a signed filter word into the 18-bit offset-binary code
    function automatic logic [17:0] post_map(input logic [23:0] x,
                                             input logic        uni,
                                             input logic        neg,
                                             input logic [2:0]  mag);
        logic signed [27:0] sum;
        logic signed [27:0] ofs;
        logic signed [27:0] s;
        logic [17:0]        code;
        sum = $signed({{4{x[23]}}, x});
        // R8 offset step scaling
        ofs = $signed(28'(mag) * ACTC_OFS_STEP);
        // R6 sign and magnitude
        if (neg) begin
            sum = sum - ofs;
        end else begin
            sum = sum + ofs;
        end
        // R1 R2 output range mapping
        if (uni) begin
            s = sum >>> ACTC_UNI_SHIFT;
        end else begin
            // R15 offset binary midpoint
            s = (sum >>> ACTC_BIP_SHIFT) + ACTC_BIP_MID;
        end
        // R16 clamp not wrap
        if (s < ACTC_RES_MIN) begin
            code = '0;
        end else if (s > ACTC_RES_MAX) begin
            code = '1;
        end else begin
            code = s[17:0];
        end
        return code;
    endfunction

    logic [7:0]  cfg_reg [3];
    logic [5:0]  ctrl_reg;
    logic [2:0]  step_reg;
    logic [23:0] res_reg;
    logic        res_valid_reg;
    logic [5:0]  sel;
    logic        sel_ok;
    logic [1:0]  sel_cfg;
    logic [2:0]  sel_tag;
    logic [7:0]  act_cfg;
    logic        accept;
    logic [23:0] word;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [23:0] fifo_out_data;
    logic        fifo_out_ready;
    logic        rd_result;
    logic [5:0]  fifo_level_reg;

    assign sel     = chan_sel(ctrl_reg, step_reg);
    assign sel_ok  = sel[5];
    assign sel_cfg = sel[4:3];
    assign sel_tag = sel[2:0];
    assign act_cfg = cfg_reg[sel_cfg];

    // Filter words taken only for a usable channel with room
    assign accept    = I_FILT_VALID && fifo_in_ready && sel_ok;
    assign rd_result = I_RD && (I_ADDR == ACTC_ADDR_RESULT);

    // R14 word layout MSB first
    // R17 reserved zeros
    assign word = {post_map(I_FILT_DATA, act_cfg[ACTC_POL_BIT],
                            act_cfg[ACTC_SIGN_BIT],
                            act_cfg[ACTC_MAG_MSB:ACTC_MAG_LSB]),
                   ACTC_RSV_ZERO, sel_tag};

    // Next word moves up when holding slot is free or being read
    assign fifo_out_ready = !res_valid_reg || rd_result;

    actc_fifo #(
        .W (ACTC_FIFO_W),
        .D (ACTC_FIFO_D)
    ) u_fifo (
        .i_clk       (I_REF_CLK),
        .i_rst       (I_RST),
        .i_in_valid  (accept),
        .i_in_data   (word),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (fifo_out_ready)
    );

    // R19 configuration registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            for (int i = 0; i < 3; i++) begin
                cfg_reg[i] <= ACTC_CFG_RESET;
            end
        end else if (I_WR) begin
            case (I_ADDR)
                ACTC_ADDR_CFG1: cfg_reg[0] <= I_WDATA;
                ACTC_ADDR_CFG2: cfg_reg[1] <= I_WDATA;
                ACTC_ADDR_CFG3: cfg_reg[2] <= I_WDATA;
                default: ;
            endcase
        end
    end

    // R13 no serial byte
    // Control register; a result-address write falls through untouched
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ctrl_reg <= ACTC_CTRL_RESET;
        end else if (I_WR && (I_ADDR == ACTC_ADDR_CTRL)) begin
            ctrl_reg <= I_WDATA[5:0];
        end
    end

    // Scan step: restarts on control write, wraps at sequence end
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            step_reg <= '0;
        end else if (I_WR && (I_ADDR == ACTC_ADDR_CTRL)) begin
            step_reg <= '0;
        end else if (accept && ctrl_reg[ACTC_CTRL_SCAN]) begin
            step_reg <= (step_reg + 3'h1 >= scan_len(ctrl_reg)) ? '0
                        : step_reg + 3'h1;
        end
    end

    // R4 held result never remapped
    // R12 writes ignored here
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            res_reg       <= '0;
            res_valid_reg <= 1'b0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            res_reg       <= fifo_out_data;
            res_valid_reg <= 1'b1;
        end else if (rd_result) begin
            res_valid_reg <= 1'b0;
        end
    end

    // Buffer level tracker for status
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            fifo_level_reg <= '0;
        end else begin
            case ({accept, fifo_out_valid && fifo_out_ready})
                2'h2:    fifo_level_reg <= fifo_level_reg + 6'h01;
                2'h1:    fifo_level_reg <= fifo_level_reg - 6'h01;
                default: fifo_level_reg <= fifo_level_reg;
            endcase
        end
    end

    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            case (I_ADDR)
                ACTC_ADDR_CFG1:   O_RDATA <= {16'h0000, cfg_reg[0]};
                ACTC_ADDR_CFG2:   O_RDATA <= {16'h0000, cfg_reg[1]};
                ACTC_ADDR_CFG3:   O_RDATA <= {16'h0000, cfg_reg[2]};
                ACTC_ADDR_RESULT: O_RDATA <= res_reg;
                ACTC_ADDR_CTRL:   O_RDATA <= {18'h00000, ctrl_reg};
                ACTC_ADDR_STATUS: O_RDATA <= {14'h0000, fifo_level_reg,
                                              step_reg, res_valid_reg};
                default:          O_RDATA <= '0;
            endcase
        end
    end

    // Front-end controls for the active channel
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_CONV_ENABLE <= 1'b0;
            O_CFG_SEL     <= '0;
            O_SOURCE_TAG  <= '0;
            O_PGA_GAIN    <= 8'h01;
            O_DAC_NEG     <= 1'b0;
            O_DAC_MAG     <= '0;
            O_DAC_CONNECT <= 1'b0;
            O_FILT_READY  <= 1'b0;
        end else begin
            O_CONV_ENABLE <= sel_ok;
            O_CFG_SEL     <= sel_cfg;
            O_SOURCE_TAG  <= sel_tag;
            // R5 power of two gain
            O_PGA_GAIN    <= 8'h01 << act_cfg[ACTC_GAIN_MSB:ACTC_GAIN_LSB];
            O_DAC_NEG     <= act_cfg[ACTC_SIGN_BIT];
            O_DAC_MAG     <= act_cfg[ACTC_MAG_MSB:ACTC_MAG_LSB];
            // R7 zero magnitude disconnects
            O_DAC_CONNECT <= (act_cfg[ACTC_MAG_MSB:ACTC_MAG_LSB] != 3'h0);
            O_FILT_READY  <= fifo_in_ready && sel_ok;
        end
    end

    // R3 modulator always bipolar
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_MOD_BIPOLAR <= 1'b1;
        end else begin
            O_MOD_BIPOLAR <= 1'b1;
        end
    end
endmodule // actc_top

// [sim/actc_top_monitor.sv]
`timescale 1ns/100ps
module actc_top_monitor
    import actc_pkg::*;
(
    input wire logic        I_REF_CLK,
    input wire logic        I_RST,
    input wire logic [2:0]  I_ADDR,
    input wire logic [7:0]  I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [23:0] O_RDATA,
    input wire logic        I_FILT_VALID,
    input wire logic        O_FILT_READY,
    input wire logic        O_CONV_ENABLE,
    input wire logic [1:0]  O_CFG_SEL,
    input wire logic [2:0]  O_SOURCE_TAG,
    input wire logic [7:0]  O_PGA_GAIN,
    input wire logic        O_DAC_NEG,
    input wire logic [2:0]  O_DAC_MAG,
    input wire logic        O_DAC_CONNECT,
    input wire logic        O_MOD_BIPOLAR
);
    logic [1:0] exp_sel;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    // Config index implied by a signal-pair tag
    assign exp_sel = O_SOURCE_TAG[2] ? O_SOURCE_TAG[1:0]
                                     : {1'b0, O_SOURCE_TAG[1]};

    a_mod_bipolar: assert property (O_MOD_BIPOLAR)
        else $error("modulator left bipolar");
    a_reset_cfg: assert property ($fell(I_RST) |->
        O_PGA_GAIN == 8'h01 && !O_DAC_CONNECT)
        else $error("config not at reset value");
    a_gain_onehot: assert property ($onehot(O_PGA_GAIN))
        else $error("gain not one-hot");
    a_dac_gate: assert property (
        O_DAC_CONNECT == (O_DAC_MAG != 3'h0))
        else $error("dac connect wrong");
    a_gain_tracks: assert property (
        (I_WR && I_ADDR == {1'b0, O_CFG_SEL} ##1 !I_WR) |=>
        O_PGA_GAIN == 8'h01 << $past(I_WDATA[7:5], 2))
        else $error("gain not following config");
    a_dac_tracks: assert property (
        (I_WR && I_ADDR == {1'b0, O_CFG_SEL} ##1 !I_WR) |=>
        {O_DAC_NEG, O_DAC_MAG} == $past(I_WDATA[3:0], 2))
        else $error("dac not following config");
    a_rsv_zero: assert property (
        I_RD && I_ADDR == ACTC_ADDR_RESULT |=>
        O_RDATA[5:3] == ACTC_RSV_ZERO)
        else $error("reserved result bits set");
    a_tag_map: assert property (
        O_SOURCE_TAG != ACTC_TAG_CAL |-> O_CFG_SEL == exp_sel)
        else $error("tag and config index disagree");
    a_bad_select_a: assert property (
        I_WR && I_ADDR == ACTC_ADDR_CTRL && I_WDATA[5:0] == 6'h07
        |-> ##2 !O_CONV_ENABLE)
        else $error("barred pair not blocked");
    a_rsvd_mode: assert property (
        I_WR && I_ADDR == ACTC_ADDR_CTRL && I_WDATA[4:3] == 2'h3
        |-> ##2 !O_CONV_ENABLE)
        else $error("reserved mode not blocked");

    c_take: cover property (I_FILT_VALID && O_FILT_READY);
    c_read: cover property (I_RD && I_ADDR == ACTC_ADDR_RESULT);
    c_block: cover property (!O_CONV_ENABLE);
endmodule // actc_top_monitor

bind actc_top actc_top_monitor i_mon (
    .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_FILT_VALID(I_FILT_VALID), .O_FILT_READY(O_FILT_READY),
    .O_CONV_ENABLE(O_CONV_ENABLE), .O_CFG_SEL(O_CFG_SEL),
    .O_SOURCE_TAG(O_SOURCE_TAG), .O_PGA_GAIN(O_PGA_GAIN),
    .O_DAC_NEG(O_DAC_NEG), .O_DAC_MAG(O_DAC_MAG),
    .O_DAC_CONNECT(O_DAC_CONNECT), .O_MOD_BIPOLAR(O_MOD_BIPOLAR));

// [sim/actc_filt_model.sv]
`timescale 1ns/100ps
module actc_filt_model (
    input  wire logic        i_clk,
    input  wire logic        i_en,
    input  wire logic [23:0] i_word,
    output logic             o_valid,
    output logic      [23:0] o_data
);
    logic        v_reg = 1'b0;
    logic [23:0] d_reg = 24'h0;

    // Word shown while enabled; idle bus toggles
    always @(posedge i_clk) begin
        v_reg <= i_en;
        d_reg <= i_en ? i_word : ~d_reg;
    end
    assign o_valid = v_reg;
    assign o_data  = d_reg;
endmodule // actc_filt_model

// [sim/actc_top_tb_top.sv]
`timescale 1ns/100ps
module actc_top_tb_top;
    import actc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        en = 1'b0;
    logic [23:0] word = 24'h0;
    logic [23:0] rdata, fdata;
    logic        fvalid, fready, conv_en, dneg, dcon, bip;
    logic [1:0]  cfg_sel;
    logic [2:0]  tag, dmag;
    logic [7:0]  gain;
    int          n_fail = 0;
    int          tests_run = 0;
    localparam logic [15:0] map_tbl [13] = '{16'h0020, 16'h0061,
        16'h00aa, 16'h00eb, 16'h0124, 16'h016d, 16'h01b6, 16'h01c0,
        16'h03b7, 16'h0267, 16'h056f, 16'h04af, 16'h0600};
    localparam logic [55:0] code_tbl [10] = '{56'h00000000800000,
        56'h10000000000000, 56'h007fffffffffc0, 56'h077fffffffffc0,
        56'h0f800000000000, 56'h01000000955540, 56'h110000002aaa80,
        56'h10400000800000, 56'h10ffffe0000000, 56'h090000006aaa80};
    localparam logic [4:0] scan_tbl [5] = '{5'h04, 5'h0d, 5'h16,
        5'h17, 5'h17};

    // Clock
    initial begin
        forever #5 clk = ~clk;
    end

    actc_top i_dut (
        .I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_FILT_VALID(fvalid),
        .I_FILT_DATA(fdata), .O_FILT_READY(fready),
        .O_CONV_ENABLE(conv_en), .O_CFG_SEL(cfg_sel),
        .O_SOURCE_TAG(tag), .O_PGA_GAIN(gain), .O_DAC_NEG(dneg),
        .O_DAC_MAG(dmag), .O_DAC_CONNECT(dcon), .O_MOD_BIPOLAR(bip));

    actc_filt_model i_src (.i_clk(clk), .i_en(en), .i_word(word),
        .o_valid(fvalid), .o_data(fdata));

    task automatic report_and_stop;
        $display("counts tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [23:0] q);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic push(input logic [23:0] x);
        @(posedge clk);
        en   <= 1'b1;
        word <= x;
        @(posedge clk);
        en <= 1'b0;
    endtask

    task automatic wait_valid;
        logic [23:0] q;
        for (int i = 0; i < 16; i++) begin
            rd_reg(ACTC_ADDR_STATUS, q);
            if (q[0] === 1'b1) return;
        end
        n_fail++;
        report_and_stop;
    endtask

    task automatic t_reset;
        logic [23:0] q;
        for (int a = 0; a < 8; a++) begin
            if (a == 3 || a == 5) continue;
            rd_reg(3'(a), q);
            chk(q, 24'h0);
        end
        chk({gain, bip, dcon, fready}, {8'h01, 3'b101});
        $display("test reset done");
    endtask

    task automatic t_cfg;
        for (int g = 0; g < 8; g++) begin
            wr_reg(ACTC_ADDR_CFG1, {3'(g), 5'h0});
            gap(2);
            chk(gain, 8'h01 << g);
        end
        for (int c = 0; c < 16; c++) begin
            wr_reg(ACTC_ADDR_CFG1, 8'(c));
            gap(2);
            chk({dneg, dmag, dcon}, {4'(c), |c[2:0]});
        end
        $display("test config done");
    endtask

    task automatic t_map;
        logic [15:0] e;
        for (int i = 0; i < 13; i++) begin
            e = map_tbl[i];
            wr_reg(ACTC_ADDR_CTRL, e[13:6]);
            gap(2);
            if (e[5]) chk({conv_en, cfg_sel, tag}, e[5:0]);
            else chk(conv_en, 1'b0);
        end
        wr_reg(ACTC_ADDR_CTRL, 8'h00);
        $display("test mapping done");
    endtask

    task automatic t_code;
        logic [55:0] e;
        logic [23:0] q;
        for (int i = 0; i < 10; i++) begin
            e = code_tbl[i];
            wr_reg(ACTC_ADDR_CFG1, e[55:48]);
            push(e[47:24]);
            wait_valid;
            rd_reg(ACTC_ADDR_RESULT, q);
            chk(q, e[23:0]);
        end
        wr_reg(ACTC_ADDR_CFG1, 8'h00);
        push(24'h0);
        wait_valid;
        wr_reg(ACTC_ADDR_CFG1, 8'h10);
        wr_reg(ACTC_ADDR_RESULT, 8'hff);
        rd_reg(ACTC_ADDR_RESULT, q);
        chk(q, 24'h800000);
        wr_reg(ACTC_ADDR_CFG1, 8'h00);
        $display("test codes done");
    endtask

    task automatic t_fill;
        logic [23:0] q;
        @(posedge clk);
        en   <= 1'b1;
        word <= 24'h0;
        gap(40);
        en <= 1'b0;
        gap(2);
        rd_reg(ACTC_ADDR_STATUS, q);
        chk(q & 24'h3f1, 24'h201);
        chk(fready, 1'b0);
        for (int i = 0; i < 33; i++) begin
            rd_reg(ACTC_ADDR_RESULT, q);
            chk(q, 24'h800000);
        end
        rd_reg(ACTC_ADDR_STATUS, q);
        chk(q & 24'h3f1, 24'h0);
        $display("test buffer done");
    endtask

    task automatic t_scan;
        logic [23:0] q;
        wr_reg(ACTC_ADDR_CTRL, 8'h2c);
        gap(2);
        for (int i = 0; i < 5; i++) begin
            chk({cfg_sel, tag}, scan_tbl[i]);
            push(24'h0);
            gap(4);
        end
        for (int i = 0; i < 5; i++) begin
            rd_reg(ACTC_ADDR_RESULT, q);
            chk(q[2:0], scan_tbl[i][2:0]);
        end
        wr_reg(ACTC_ADDR_CTRL, 8'h00);
        $display("test scan done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_cfg;
        t_map;
        t_code;
        t_fill;
        t_scan;
        report_and_stop;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end
endmodule // actc_top_tb_top
